// file: rtl/dps_host.sv
/*
 * host controller driving one port of a 2K x 8 dual-port static ram.
 * assumes a request interface synchronous to i_ref_clk and the ram pins
 * routed straight to the device; the bench resolves the data bus.
 */
// Summary of operation
// - read: r/w high, ce and oe low, address valid before ce falls.
// - master/slave: r/w low only after busy-from-address delay.
// - oe low during write: pulse is max of width or hi-z plus setup.
// - oe high during write: pulse may be the minimum width.
// - ce held low at least chip-enable-to-end-of-write before write ends.
// - address valid at least address-to-end-of-write before write ends.
// - write data stable at least data-to-end-of-write before write ends.
// - r/w or ce high whenever address changes.
`timescale 1ns/1ps
`include "dps_regs.svh"

module dps_host
   import dps_pkg::*;
#(
   parameter int AW          = 11,
   parameter int DW          = 8,
   parameter bit SLAVE_MODE  = 1'b0,   // master/slave expansion: wait for busy
   parameter bit OE_IN_WRITE = 1'b0    // keep oe low during writes
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_b,
   input  wire logic          i_req,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic          i_busy_b,
   input  wire logic [DW-1:0] i_io_in,
   output logic               o_ack,
   output logic [DW-1:0]      o_rdata,
   output logic               o_idle,
   output logic [AW-1:0]      o_ram_addr,
   output logic               o_ram_ce_b,
   output logic               o_ram_oe_b,
   output logic               o_ram_rw_b,
   output logic [DW-1:0]      o_io_out,
   output logic               o_io_oe_b
);

   // write pulse length: oe low needs room for the device drivers to turn off
   // whole cycles waste up to one period per figure but need no tuning
   function automatic dps_cnt_t wp_len(input bit oe_low);
      int n;
      n = `DPS_WP_CYC;
      if (oe_low && (`DPS_WZDW_CYC > n)) begin
         n = `DPS_WZDW_CYC;
      end
      wp_len = dps_cnt_t'(n);
   endfunction : wp_len

   dps_state_e      state_r, state_nxt;
   dps_cnt_t        cnt_r, cnt_nxt;
   logic [AW-1:0]   addr_r, addr_nxt;
   logic [DW-1:0]   dout_r, dout_nxt;
   logic [DW-1:0]   rdata_r, rdata_nxt;
   logic            ce_b_r, ce_b_nxt;
   logic            oe_b_r, oe_b_nxt;
   logic            rw_b_r, rw_b_nxt;
   logic            iooe_b_r, iooe_b_nxt;
   logic            ack_r, ack_nxt;

   // named decode terms
   wire logic cnt_zero = (cnt_r == dps_cnt_t'(0));
   wire logic busy_now = ~i_busy_b;
   // write pulse measured from ce/rw overlap; ewp covers both tew and twp
   // a pulse longer than a minimum costs a cycle per write, never a violation
   wire dps_cnt_t pulse_cnt = (wp_len(OE_IN_WRITE) > dps_cnt_t'(`DPS_EW_CYC)) ?
                              wp_len(OE_IN_WRITE) : dps_cnt_t'(`DPS_EW_CYC);
   // master/slave: write cycle stretched by busy-from-address delay
   wire dps_cnt_t wset_cnt  = SLAVE_MODE ? dps_cnt_t'(`DPS_BAA_CYC) : dps_cnt_t'(0);

   // next state and pin sequencing
   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_zero ? cnt_r : cnt_r - dps_cnt_t'(1);
      addr_nxt      = addr_r;
      dout_nxt      = dout_r;
      rdata_nxt     = rdata_r;
      ce_b_nxt      = ce_b_r;
      oe_b_nxt      = oe_b_r;
      rw_b_nxt      = rw_b_r;
      iooe_b_nxt    = iooe_b_r;
      ack_nxt       = 1'b0;
      case (state_r)
         DPS_IDLE: begin
            if (i_req) begin
               // address moves only while ce and r/w are high
               addr_nxt      = i_addr;
               dout_nxt      = i_wdata;
               state_nxt     = i_we ? DPS_WSET : DPS_RSET;
               cnt_nxt       = wset_cnt;
            end
         end
         DPS_RSET: begin
            // address already stable; ce and oe fall together
            ce_b_nxt  = 1'b0;
            oe_b_nxt  = 1'b0;
            rw_b_nxt  = 1'b1;
            cnt_nxt   = dps_cnt_t'(`DPS_RD_CYC);
            state_nxt = DPS_RWAIT;
         end
         DPS_RWAIT: begin
            // a busy seen means the far port writes here: add release delay
            // busy low again restarts the delay, so a long collision is covered
            if (busy_now) begin
               cnt_nxt = dps_cnt_t'(`DPS_BUSY_DATA_CYC);
            end else if (cnt_zero) begin
               // latest of access times has elapsed; with busy high the flag
               // plays no part, as when both ports only read
               rdata_nxt = i_io_in;
               state_nxt = DPS_RDONE;
            end
         end
         DPS_RDONE: begin
            // outputs release on first deasserted enable
            ce_b_nxt  = 1'b1;
            oe_b_nxt  = 1'b1;
            ack_nxt   = 1'b1;
            cnt_nxt   = dps_cnt_t'(`DPS_HZ_CYC);
            state_nxt = DPS_TURN;
         end
         DPS_WSET: begin
            // slave waits out busy access delay before r/w falls
            if (cnt_zero && !(SLAVE_MODE && busy_now)) begin
               ce_b_nxt   = 1'b0;
               rw_b_nxt   = 1'b0;
               oe_b_nxt   = ~OE_IN_WRITE;
               iooe_b_nxt = 1'b0;
               cnt_nxt    = pulse_cnt;
               state_nxt  = DPS_WPUL;
            end
         end
         DPS_WPUL: begin
            // address and data held through the pulse
            if (cnt_zero) begin
               ce_b_nxt  = 1'b1;
               rw_b_nxt  = 1'b1;
               state_nxt = DPS_WEND;
            end
         end
         DPS_WEND: begin
            // data hold of zero; release bus one cycle after end of write
            // the extra cycle keeps write data on the pins past the rising edge
            iooe_b_nxt = 1'b1;
            oe_b_nxt   = 1'b1;
            ack_nxt    = 1'b1;
            cnt_nxt    = dps_cnt_t'(0);
            state_nxt  = DPS_TURN;
         end
         DPS_TURN: begin
            // bus turnaround so the device drivers are off before next access
            if (cnt_zero) begin
               state_nxt = DPS_IDLE;
            end
         end
         default: begin
            state_nxt = DPS_IDLE;
         end
      endcase
   end

   // state and pin registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r     <= DPS_IDLE;
         cnt_r       <= '0;
         addr_r      <= '0;
         dout_r      <= '0;
         rdata_r     <= '0;
         ce_b_r      <= 1'b1;
         oe_b_r      <= 1'b1;
         rw_b_r      <= 1'b1;
         iooe_b_r    <= 1'b1;
         ack_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         addr_r      <= addr_nxt;
         dout_r      <= dout_nxt;
         rdata_r     <= rdata_nxt;
         ce_b_r      <= ce_b_nxt;
         oe_b_r      <= oe_b_nxt;
         rw_b_r      <= rw_b_nxt;
         iooe_b_r    <= iooe_b_nxt;
         ack_r       <= ack_nxt;
      end
   end

   // idle flag registered alongside state
   // taken from the next state so the flag rises with the return to idle
   logic idle_r;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         idle_r <= 1'b1;
      end else begin
         idle_r <= (state_nxt == DPS_IDLE);
      end
   end

   assign o_ack      = ack_r;
   assign o_rdata    = rdata_r;
   assign o_idle     = idle_r;
   assign o_ram_addr = addr_r;
   assign o_ram_ce_b = ce_b_r;
   assign o_ram_oe_b = oe_b_r;
   assign o_ram_rw_b = rw_b_r;
   assign o_io_out   = dout_r;
   assign o_io_oe_b  = iooe_b_r;

endmodule : dps_host

// file: rtl/dps_pkg.sv
/*
 * types for the dual-port sram host port controller.
 * assumes nothing of its surroundings.
 */
package dps_pkg;
   typedef enum logic [2:0] {
      DPS_IDLE  = 3'b000,
      DPS_RSET  = 3'b001,
      DPS_RWAIT = 3'b010,
      DPS_RDONE = 3'b011,
      DPS_WSET  = 3'b100,
      DPS_WPUL  = 3'b101,
      DPS_WEND  = 3'b110,
      DPS_TURN  = 3'b111
   } dps_state_e;
   typedef logic [7:0] dps_cnt_t;
endpackage : dps_pkg

// file: rtl/dps_regs.svh
/*
 * timing constants for the dual-port sram host port controller.
 * assumes a 100 MHz reference clock; the includer uses the counts.
 */
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

// clock period in ns
`define DPS_CLK_NS        10
// read side figures, fastest grade, ns
`define DPS_T_ACC_NS      20
`define DPS_T_BUSY_DATA_NS 25
// write side figures, fastest grade, ns
`define DPS_T_EW_NS       15
`define DPS_T_WP_NS       15
`define DPS_T_WZ_NS       10
`define DPS_T_DW_NS       10
`define DPS_T_BAA_NS      20
`define DPS_T_HZ_NS       10

// ceiling division to whole cycles, at least one
`define DPS_CYC(ns)       ((((ns) + `DPS_CLK_NS - 1) / `DPS_CLK_NS) < 1 ? 1 : \
                           (((ns) + `DPS_CLK_NS - 1) / `DPS_CLK_NS))

`define DPS_RD_CYC        `DPS_CYC(`DPS_T_ACC_NS)
`define DPS_BUSY_DATA_CYC `DPS_CYC(`DPS_T_BUSY_DATA_NS)
`define DPS_WP_CYC        `DPS_CYC(`DPS_T_WP_NS)
`define DPS_WZDW_CYC      `DPS_CYC(`DPS_T_WZ_NS + `DPS_T_DW_NS)
`define DPS_EW_CYC        `DPS_CYC(`DPS_T_EW_NS)
`define DPS_BAA_CYC       `DPS_CYC(`DPS_T_BAA_NS)
`define DPS_HZ_CYC        `DPS_CYC(`DPS_T_HZ_NS)

`endif

// file: verification/dps_host_checker.sv
/* pin-level assertions for dps_host, parameters passed by the bind.
   assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module dps_chk
   import dps_pkg::*;
#(
   parameter int AW          = 11,
   parameter int DW          = 8,
   parameter bit SLAVE_MODE  = 1'b0,
   parameter bit OE_IN_WRITE = 1'b0
) (
   input wire logic          i_ref_clk,
   input wire logic          i_rst_b,
   input wire logic          i_req,
   input wire logic          i_we,
   input wire logic          o_ack,
   input wire logic          o_idle,
   input wire logic [AW-1:0] o_ram_addr,
   input wire logic          o_ram_ce_b,
   input wire logic          o_ram_oe_b,
   input wire logic          o_ram_rw_b,
   input wire logic [DW-1:0] o_io_out,
   input wire logic          o_io_oe_b
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // request taken; start of a write strobe with the chip selected
   sequence s_take; o_idle && i_req; endsequence
   sequence s_wr_go; $fell(o_ram_rw_b) && !o_ram_ce_b; endsequence
   // 15 ns minimums round up to two whole cycles
   // oe held low in writes may fall only together with r/w
   property p_rd_setup;
      $fell(o_ram_oe_b) |-> !o_ram_ce_b && $stable(o_ram_addr) &&
         (o_ram_rw_b || (OE_IN_WRITE && $fell(o_ram_rw_b)));
   endproperty
   a_rd_setup: assert property (p_rd_setup) else $error("read setup");
   property p_addr_move;
      !$stable(o_ram_addr) |-> ($past(o_ram_ce_b) || $past(o_ram_rw_b)) &&
         (o_ram_ce_b || o_ram_rw_b);
   endproperty
   a_addr_move: assert property (p_addr_move) else $error("addr moved in write");
   property p_wr_ce; s_wr_go |-> !o_ram_ce_b [*2]; endproperty
   a_wr_ce: assert property (p_wr_ce) else $error("ce short");
   property p_wr_addr; s_wr_go |-> $stable(o_ram_addr) [*2]; endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("addr short");
   property p_wr_pulse; s_wr_go |-> (!o_ram_rw_b && (o_ram_oe_b != OE_IN_WRITE)) [*2]; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("pulse short");
   // slave: r/w stays high through the busy access delay after the address moves
   property p_slave_wait;
      SLAVE_MODE && o_idle && i_req && i_we |-> o_ram_rw_b [*4];
   endproperty
   a_slave_wait: assert property (p_slave_wait) else $error("r/w fell early");
   property p_wr_data; !o_ram_rw_b |-> !o_io_oe_b && $stable(o_io_out); endproperty
   a_wr_data: assert property (p_wr_data) else $error("data unstable");
   property p_no_clash; !o_io_oe_b |-> o_ram_oe_b || o_ram_ce_b || !o_ram_rw_b; endproperty
   a_no_clash: assert property (p_no_clash) else $error("bus clash");
   property p_answer; s_take |-> ##[5:20] o_ack; endproperty
   a_answer: assert property (p_answer) else $error("no ack");
endmodule : dps_chk
bind dps_host dps_chk #(.AW(AW), .DW(DW), .SLAVE_MODE(SLAVE_MODE), .OE_IN_WRITE(OE_IN_WRITE))
   u_chk (.i_ref_clk, .i_rst_b, .i_req, .i_we, .o_ack, .o_idle, .o_ram_addr, .o_ram_ce_b,
   .o_ram_oe_b, .o_ram_rw_b, .o_io_out, .o_io_oe_b);

// file: verification/dps_ram_model.sv
/* behavioural model of one port of the dual-port ram.
   assumes the bench resolves the shared data bus. */
`timescale 1ns/1ps
module dps_ram_model #(
   parameter int AW = 11,
   parameter int DW = 8
) (
   input  wire logic [AW-1:0] i_addr,
   input  wire logic          i_ce_b,
   input  wire logic          i_oe_b,
   input  wire logic          i_rw_b,
   input  wire logic          i_busy_b,
   input  wire logic [DW-1:0] i_io,
   output logic      [DW-1:0] o_io
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] last_r = '0;
   wire           rd_sel = !i_ce_b && !i_oe_b && i_rw_b;
   wire           wr_on  = !i_ce_b && !i_rw_b;
   wire           rd_acc;
   wire           busy_ok;
   wire           drv;
   // data valid only after the slowest path; a short select never shows
   assign #20 rd_acc = rd_sel;
   assign #25 busy_ok = i_busy_b;
   assign drv  = rd_sel && rd_acc && busy_ok && i_busy_b;
   // floating bus shows the inverse so a stale value never passes
   assign o_io = drv ? mem[i_addr] : ~last_r;
   always @(negedge wr_on) mem[i_addr] = i_io;
   always @(o_io) if (drv) last_r = o_io;
endmodule : dps_ram_model

// file: verification/tb.sv
/* self-checking bench for two dps_host ports against the ram model.
   assumes one default port, one slave port with oe low in writes,
   and the checker bound to dps_host. */
`timescale 1ns/1ps
module tb;
   import dps_pkg::*;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_b   = 1'b0;
   logic        i_req     = 1'b0;
   logic        i_we      = 1'b0;
   logic [10:0] i_addr    = '0;
   logic [7:0]  i_wdata   = '0;
   logic        i_busy_b  = 1'b1;
   wire  [7:0]  i_io_in, o_io_out, ram_io, o_rdata;
   wire  [10:0] o_ram_addr;
   wire         o_ack, o_idle, o_ram_ce_b, o_ram_oe_b, o_ram_rw_b, o_io_oe_b;
   wire  [7:0]  s_io_in, s_io_out, s_ram_io, s_rdata;
   wire  [10:0] s_ram_addr;
   wire         s_ack, s_idle, s_ram_ce_b, s_ram_oe_b, s_ram_rw_b, s_io_oe_b;
   int          err_total  = 0;
   int          n_compared = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   // host wins the bus while it drives, else the ram
   assign i_io_in = !o_io_oe_b ? o_io_out : ram_io;
   dps_host dut (.i_ref_clk, .i_rst_b, .i_req, .i_we, .i_addr, .i_wdata, .i_busy_b,
      .i_io_in, .o_ack, .o_rdata, .o_idle, .o_ram_addr, .o_ram_ce_b, .o_ram_oe_b,
      .o_ram_rw_b, .o_io_out, .o_io_oe_b);
   dps_ram_model ram (.i_addr(o_ram_addr), .i_ce_b(o_ram_ce_b), .i_oe_b(o_ram_oe_b),
      .i_rw_b(o_ram_rw_b), .i_busy_b(i_busy_b), .i_io(i_io_in), .o_io(ram_io));
   // second port shares the requests; slave expansion, oe low in writes
   assign s_io_in = !s_io_oe_b ? s_io_out : s_ram_io;
   dps_host #(.SLAVE_MODE(1'b1), .OE_IN_WRITE(1'b1)) dut_s (.i_ref_clk, .i_rst_b, .i_req,
      .i_we, .i_addr, .i_wdata, .i_busy_b, .i_io_in(s_io_in), .o_ack(s_ack),
      .o_rdata(s_rdata), .o_idle(s_idle), .o_ram_addr(s_ram_addr), .o_ram_ce_b(s_ram_ce_b),
      .o_ram_oe_b(s_ram_oe_b), .o_ram_rw_b(s_ram_rw_b), .o_io_out(s_io_out),
      .o_io_oe_b(s_io_oe_b));
   dps_ram_model ram_s (.i_addr(s_ram_addr), .i_ce_b(s_ram_ce_b), .i_oe_b(s_ram_oe_b),
      .i_rw_b(s_ram_rw_b), .i_busy_b(i_busy_b), .i_io(s_io_in), .o_io(s_ram_io));
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask : check
   // one transfer; latency counted in cycles from the negedge that raises the request to ack
   // alt waits on the slave port's ack instead of the default port's
   task automatic op(input logic we, input logic [10:0] a, input logic [7:0] d, input bit alt,
                     output int lat);
      i_req = 1'b1;
      i_we = we;
      i_addr = a;
      i_wdata = d;
      @(negedge i_ref_clk);
      i_req = 1'b0;
      lat = 1;
      while ((alt ? s_ack : o_ack) !== 1'b1) begin
         if (lat > 40) begin
            err_total++;
            complete_run();
         end
         @(negedge i_ref_clk);
         lat++;
      end
      repeat (2) @(negedge i_ref_clk);
   endtask : op
   // writes then reads at both address extremes and two alternating patterns, back to back
   task automatic t_rw();
      logic [10:0] a [4] = '{11'h000, 11'h7ff, 11'h2a5, 11'h55a};
      int lat;
      foreach (a[k]) begin
         op(1'b1, a[k], 8'h3c ^ a[k][7:0], 1'b0, lat);
         check(lat, 6, "write latency");
      end
      foreach (a[k]) begin
         op(1'b0, a[k], 8'h00, 1'b0, lat);
         check(lat, 6, "read latency");
         check(o_rdata, 8'h3c ^ a[k][7:0], "read data");
      end
      $display("t_rw done");
   endtask : t_rw
   // busy held low across a read must stretch it and still give good data
   task automatic t_busy();
      int lat;
      op(1'b1, 11'h123, 8'ha5, 1'b0, lat);
      i_busy_b = 1'b0;
      fork
         op(1'b0, 11'h123, 8'h00, 1'b0, lat);
         begin
            repeat (4) @(negedge i_ref_clk);
            i_busy_b = 1'b1;
         end
      join
      check(lat > 6, 1, "busy stretch");
      check(o_rdata, 8'ha5, "busy data");
      $display("t_busy done");
   endtask : t_busy
   // slave port: r/w waits two cycles more, oe low in write still stores data
   task automatic t_alt();
      int lat;
      op(1'b1, 11'h456, 8'h5a, 1'b1, lat);
      check(lat, 8, "slave write latency");
      op(1'b0, 11'h456, 8'h00, 1'b1, lat);
      check(lat, 6, "slave read latency");
      check(s_rdata, 8'h5a, "oe low write data");
      $display("t_alt done");
   endtask : t_alt
   initial begin
      repeat (10) @(negedge i_ref_clk);
      check({o_ram_ce_b, o_ram_oe_b, o_ram_rw_b, o_io_oe_b, o_idle}, 5'h1f, "reset");
      i_rst_b = 1'b1;
      @(negedge i_ref_clk);
      t_rw();
      t_busy();
      t_alt();
      complete_run();
   end
endmodule : tb
